// ==== rtl/trmc_params.svh ====
// Constants of the trigger and run-mode sequencer
`ifndef TRMC_PARAMS_SVH
`define TRMC_PARAMS_SVH
`define TRMC_ADDR_CTRL     12'h000
`define TRMC_ADDR_TRIGDLY  12'h004
`define TRMC_ADDR_RETRDLY  12'h008
`define TRMC_ADDR_BURST    12'h00C
`define TRMC_ADDR_FILTER   12'h010
`define TRMC_ADDR_CMD      12'h014
`define TRMC_ADDR_STATUS   12'h018
`define TRMC_CTRL_MODE_LSB   0
`define TRMC_CTRL_SRC_LSB    3
`define TRMC_CTRL_SLOPE_BIT  5
`define TRMC_CTRL_OUTEN_BIT  6
`define TRMC_CTRL_SEQ_BIT    7
`define TRMC_CMD_TRIG_BIT    0
`define TRMC_FILT_EN_BIT     2
`define TRMC_SYS_LAT_CYC     6
`define TRMC_PERIOD_NS       100
`define TRMC_STEP_NS         20
`define TRMC_DLY_MIN_NS      200
`define TRMC_DLY_MAX_STEPS   1000000000
`define TRMC_BURST_MAX       1048576
`define TRMC_RST_CTRL        8'h00
`define TRMC_RST_BURST       21'h000001
`endif

// ==== rtl/trmc_pkg.sv ====
// Types of the trigger and run-mode sequencer
package trmc_pkg;
    typedef enum logic [2:0] {
        TRMC_RUN_CONT = 3'h0,
        TRMC_RUN_TRIG = 3'h1,
        TRMC_RUN_BRST = 3'h2,
        TRMC_RUN_GATE = 3'h3,
        TRMC_RUN_MIX  = 3'h4
    } trmc_mode_t;
    typedef enum logic [1:0] {
        TRMC_SRC_EXT = 2'h0,
        TRMC_SRC_BUS = 2'h1,
        TRMC_SRC_MIX = 2'h2
    } trmc_src_t;
    typedef enum logic [4:0] {
        TRMC_ST_IDLE  = 5'h01,
        TRMC_ST_LAT   = 5'h02,
        TRMC_ST_DLY   = 5'h04,
        TRMC_ST_PLAY  = 5'h08,
        TRMC_ST_HOLD  = 5'h10
    } trmc_state_t;
endpackage

// ==== rtl/trmc_core.sv ====
// Trigger and run-mode sequencer with APB register file
`timescale 1ns/1ps
`include "trmc_params.svh"
module trmc_core #(
    parameter int CHANNELS  = 4,
    parameter int CNT_W     = 32,
    parameter int SYS_LAT   = `TRMC_SYS_LAT_CYC
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [11:0]           paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    input  wire logic                  external_trigger_input_i,
    input  wire logic                  manual_trigger_i,
    input  wire logic                  gate_i,
    input  wire logic                  cycle_end_i,
    input  wire logic [CHANNELS-1:0]   std_shape_i,
    output logic                       play_o,
    output logic                       output_on_o,
    output logic [CHANNELS-1:0]        filt_en_o,
    output logic [2*CHANNELS-1:0]      filt_sel_o
);
    import trmc_pkg::*;

    // Delay in clocks = ceil(steps*20ns / period)
    localparam int STEP_NS = `TRMC_STEP_NS;
    localparam int PER_NS  = `TRMC_PERIOD_NS;
    localparam int MIN_STEPS = `TRMC_DLY_MIN_NS / `TRMC_STEP_NS;

    if (CHANNELS < 1 || CHANNELS > 8 ||
        CNT_W < 32 || SYS_LAT < 1) begin : g_bad_param
        $error("trmc_core: unsupported parameter values");
    end

    logic [7:0]          ctrl_ff;
    logic [31:0]         tdly_ff;
    logic [31:0]         rdly_ff;
    logic [20:0]         burst_ff;
    logic [3*CHANNELS-1:0] filt_ff;
    trmc_state_t         st_ff, nxt_st;
    logic [CNT_W-1:0]    cnt_ff, nxt_cnt;
    logic [20:0]         cyc_ff, nxt_cyc;
    trmc_mode_t          amode_ff;
    logic [31:0]         artr_ff;
    logic                ext_q_ff, man_q_ff, mixfirst_ff;
    logic                bus_trig_ff;

    // APB decode
    wire acc   = psel_i & penable_i;
    wire wr    = acc & pwrite_i;
    wire hit_ctrl = (paddr_i == `TRMC_ADDR_CTRL);
    wire hit_td   = (paddr_i == `TRMC_ADDR_TRIGDLY);
    wire hit_rd   = (paddr_i == `TRMC_ADDR_RETRDLY);
    wire hit_bu   = (paddr_i == `TRMC_ADDR_BURST);
    wire hit_fi   = (paddr_i == `TRMC_ADDR_FILTER);
    wire hit_cmd  = (paddr_i == `TRMC_ADDR_CMD);
    wire hit_st   = (paddr_i == `TRMC_ADDR_STATUS);
    wire mapped   = hit_ctrl | hit_td | hit_rd | hit_bu | hit_fi
                  | hit_cmd | hit_st;
    assign pready_o  = 1'b1;
    assign pslverr_o = acc & ~mapped;

    trmc_mode_t mode;
    trmc_src_t  src;
    assign mode = trmc_mode_t'(ctrl_ff[`TRMC_CTRL_MODE_LSB +: 3]);
    assign src  = trmc_src_t'(ctrl_ff[`TRMC_CTRL_SRC_LSB +: 2]);
    wire slope_fall = ctrl_ff[`TRMC_CTRL_SLOPE_BIT];
    wire seq_on     = ctrl_ff[`TRMC_CTRL_SEQ_BIT];

    // Trigger qualification; pins already synchronous to sys_clk
    wire ext_edge = slope_fall ? (ext_q_ff & ~external_trigger_input_i)
                               : (~ext_q_ff & external_trigger_input_i);
    wire man_edge = manual_trigger_i & ~man_q_ff;
    wire ext_trig = ext_edge | man_edge;
    wire bus_cmd  = wr & hit_cmd & pwdata_i[`TRMC_CMD_TRIG_BIT];
    wire src_trig = (src == TRMC_SRC_EXT) ? ext_trig :
                    (src == TRMC_SRC_BUS) ? bus_trig_ff :
                    (mixfirst_ff ? ext_trig : bus_trig_ff);
    // Mixed run: software first, rear input afterwards
    wire mix_trig = mixfirst_ff ? bus_trig_ff : ext_edge;
    wire trig     = (mode == TRMC_RUN_MIX) ? mix_trig : src_trig;
    wire gate_on  = gate_i;
    wire idle     = (st_ff == TRMC_ST_IDLE);
    wire start    = idle & ((mode == TRMC_RUN_CONT) |
                    ((mode == TRMC_RUN_GATE) & gate_on) |
                    ((mode != TRMC_RUN_CONT) & (mode != TRMC_RUN_GATE)
                     & trig));
    wire [CNT_W-1:0] tdly_cyc =
        CNT_W'((64'(tdly_ff) * STEP_NS + PER_NS - 1) / PER_NS);
    wire [CNT_W-1:0] rdly_cyc =
        CNT_W'((64'(artr_ff) * STEP_NS + PER_NS - 1) / PER_NS);
    // Free run leaves only at a cycle end, once the mode is changed
    wire last_cyc = (amode_ff == TRMC_RUN_BRST) ? (cyc_ff <= 21'h000001)
                  : (amode_ff == TRMC_RUN_GATE) ? ~gate_on
                  : (amode_ff == TRMC_RUN_CONT) ? (mode != TRMC_RUN_CONT)
                  : 1'b1;

    always_comb begin
        nxt_st  = st_ff;
        nxt_cnt = cnt_ff;
        nxt_cyc = cyc_ff;
        unique case (st_ff)
            TRMC_ST_IDLE: begin
                if (start) begin
                    nxt_st  = TRMC_ST_LAT;
                    nxt_cnt = CNT_W'(SYS_LAT - 1);
                    nxt_cyc = seq_on ? 21'h000001 : burst_ff;
                end
            end
            TRMC_ST_LAT: begin
                if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - 1'b1;
                end else if (tdly_cyc != '0) begin
                    nxt_st  = TRMC_ST_DLY;
                    nxt_cnt = tdly_cyc - 1'b1;
                end else begin
                    nxt_st  = TRMC_ST_PLAY;
                end
            end
            TRMC_ST_DLY: begin
                if (cnt_ff != '0) nxt_cnt = cnt_ff - 1'b1;
                else nxt_st = TRMC_ST_PLAY;
            end
            TRMC_ST_PLAY: begin
                // Stop only at a cycle boundary
                if (cycle_end_i) begin
                    nxt_cyc = cyc_ff - 1'b1;
                    if (last_cyc) begin
                        nxt_st = (rdly_cyc != '0) ? TRMC_ST_HOLD
                                                  : TRMC_ST_IDLE;
                        nxt_cnt = rdly_cyc - 1'b1;
                    end
                end
            end
            TRMC_ST_HOLD: begin
                if (cnt_ff != '0) nxt_cnt = cnt_ff - 1'b1;
                else nxt_st = TRMC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            st_ff       <= TRMC_ST_IDLE;
            cnt_ff      <= '0;
            cyc_ff      <= '0;
            amode_ff    <= TRMC_RUN_CONT;
            artr_ff     <= '0;
            ext_q_ff    <= 1'b0;
            man_q_ff    <= 1'b0;
            mixfirst_ff <= 1'b1;
            bus_trig_ff <= 1'b0;
        end else begin
            st_ff       <= nxt_st;
            cnt_ff      <= nxt_cnt;
            cyc_ff      <= nxt_cyc;
            ext_q_ff    <= external_trigger_input_i;
            man_q_ff    <= manual_trigger_i;
            bus_trig_ff <= bus_cmd;
            if (start) begin
                amode_ff <= mode;
                artr_ff  <= rdly_ff;
                mixfirst_ff <= 1'b0;
            end
            if (wr & hit_ctrl) mixfirst_ff <= 1'b1;
        end
    end

    // Register writes; out-of-range delays clamp to the legal span
    wire [31:0] dly_w = (pwdata_i == 32'h0) ? 32'h0 :
        (pwdata_i < 32'(MIN_STEPS)) ? 32'(MIN_STEPS) :
        (pwdata_i > `TRMC_DLY_MAX_STEPS) ? 32'(`TRMC_DLY_MAX_STEPS)
        : pwdata_i;
    wire [20:0] bst_w = (pwdata_i == 32'h0) ? 21'h000001 :
        (pwdata_i > `TRMC_BURST_MAX) ? 21'h100000 : pwdata_i[20:0];

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            ctrl_ff  <= `TRMC_RST_CTRL;
            tdly_ff  <= '0;
            rdly_ff  <= '0;
            burst_ff <= `TRMC_RST_BURST;
            filt_ff  <= '0;
        end else if (wr) begin
            if (hit_ctrl) ctrl_ff <= pwdata_i[7:0];
            if (hit_td) tdly_ff <= dly_w;
            if (hit_rd) rdly_ff <= (pwdata_i == 32'h0) ? 32'(MIN_STEPS)
                                                      : dly_w;
            if (hit_bu) burst_ff <= bst_w;
            if (hit_fi) filt_ff <= pwdata_i[3*CHANNELS-1:0];
        end
    end

    // Burst not offered with sequences: plays as single cycle
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0;
        if (hit_ctrl) rdata = {24'h0, ctrl_ff};
        if (hit_td)   rdata = tdly_ff;
        if (hit_rd)   rdata = rdly_ff;
        if (hit_bu)   rdata = {11'h0, burst_ff};
        if (hit_fi)   rdata = 32'(filt_ff);
        if (hit_st)   rdata = {5'h00, cyc_ff, mixfirst_ff, st_ff};
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            prdata_o <= 32'h0;
            play_o   <= 1'b0;
            output_on_o <= 1'b0;
        end else begin
            if (psel_i & ~penable_i & ~pwrite_i) prdata_o <= rdata;
            play_o      <= (nxt_st == TRMC_ST_PLAY);
            output_on_o <= ctrl_ff[`TRMC_CTRL_OUTEN_BIT];
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            // Standard shapes always need reconstruction
            assign filt_en_o[g] = std_shape_i[g] |
                                  filt_ff[3*g+`TRMC_FILT_EN_BIT];
            assign filt_sel_o[2*g +: 2] = filt_ff[3*g +: 2];
        end
    endgenerate

    a_lat_start: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (idle && start) |-> ##1 (st_ff == TRMC_ST_LAT)[*6])
        else $error("latency phase too short");
    a_busy_ignore: assert property (@(posedge sys_clk_i)
        disable iff (!rst_b_i)
        (st_ff == TRMC_ST_PLAY && !cycle_end_i) |=> st_ff == TRMC_ST_PLAY)
        else $error("play ended mid cycle");
    a_cont_free: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (idle && mode == TRMC_RUN_CONT) |=> st_ff == TRMC_ST_LAT)
        else $error("continuous mode waited");
    a_outen_reg: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $changed(output_on_o) |-> $past(wr && hit_ctrl, 2))
        else $error("output state changed without command");
    a_filt_std: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (std_shape_i != '0) |-> ((filt_en_o & std_shape_i) == std_shape_i))
        else $error("standard shape without filter");
    a_trig_one: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_ff == TRMC_ST_PLAY && cycle_end_i && amode_ff == TRMC_RUN_TRIG)
        |=> st_ff != TRMC_ST_PLAY)
        else $error("triggered mode played more than one cycle");
    a_hold_min: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(st_ff == TRMC_ST_HOLD) |-> (st_ff == TRMC_ST_HOLD)[*2])
        else $error("re-trigger holdoff too short");
    a_burst_rng: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        burst_ff >= 21'h000001 && burst_ff <= 21'h100000)
        else $error("burst count out of range");
    a_idle_stay: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (idle && !start) |=> idle)
        else $error("left idle without a start");
    a_lat_next: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_ff == TRMC_ST_LAT && cnt_ff != '0) |=> st_ff == TRMC_ST_LAT)
        else $error("latency ended early");
    a_lat_exit: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_ff == TRMC_ST_LAT && cnt_ff == '0 && tdly_cyc != '0)
        |=> st_ff == TRMC_ST_DLY)
        else $error("trigger delay skipped");
    a_dly_skip: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_ff == TRMC_ST_LAT && cnt_ff == '0 && tdly_cyc == '0)
        |=> st_ff == TRMC_ST_PLAY)
        else $error("delay off but playback late");
    a_dly_count: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_ff == TRMC_ST_DLY && cnt_ff != '0) |=> st_ff == TRMC_ST_DLY)
        else $error("trigger delay ended early");
    a_dly_play: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_ff == TRMC_ST_DLY && cnt_ff == '0) |=> st_ff == TRMC_ST_PLAY)
        else $error("trigger delay overran");
    a_hold_count: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_ff == TRMC_ST_HOLD && cnt_ff != '0) |=> st_ff == TRMC_ST_HOLD)
        else $error("holdoff ended early");
    a_hold_idle: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_ff == TRMC_ST_HOLD && cnt_ff == '0) |=> idle)
        else $error("holdoff overran");
    a_play_match: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        play_o == (st_ff == TRMC_ST_PLAY))
        else $error("play output disagrees with state");
    a_cont_stay: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_ff == TRMC_ST_PLAY && amode_ff == TRMC_RUN_CONT
         && mode == TRMC_RUN_CONT) |=> st_ff == TRMC_ST_PLAY)
        else $error("continuous playback interrupted");
    a_burst_more: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_ff == TRMC_ST_PLAY && cycle_end_i && amode_ff == TRMC_RUN_BRST
         && cyc_ff > 21'h000001) |=> st_ff == TRMC_ST_PLAY)
        else $error("burst stopped before its count");
    a_burst_load: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (idle && start && !seq_on) |=> cyc_ff == $past(burst_ff))
        else $error("burst count not loaded");
    a_seq_single: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (idle && start && seq_on) |=> cyc_ff == 21'h000001)
        else $error("burst applied during sequence");
    a_gate_stop: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_ff == TRMC_ST_PLAY && cycle_end_i && amode_ff == TRMC_RUN_GATE
         && !gate_i) |=> st_ff != TRMC_ST_PLAY)
        else $error("gate off ignored");
    a_gate_start: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (idle && mode == TRMC_RUN_GATE && gate_i) |=> st_ff == TRMC_ST_LAT)
        else $error("gate on ignored");
    a_mix_first: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (idle && mode == TRMC_RUN_MIX && mixfirst_ff && !bus_trig_ff)
        |=> idle)
        else $error("mixed run started without software trigger");
    a_mix_later: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (idle && mode == TRMC_RUN_MIX && !mixfirst_ff && !ext_edge)
        |=> idle)
        else $error("mixed run restarted without rear trigger");
    a_bus_only: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (idle && mode == TRMC_RUN_TRIG && src == TRMC_SRC_BUS
         && !bus_trig_ff) |=> idle)
        else $error("bus source started without command");
    a_ext_only: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (idle && mode == TRMC_RUN_TRIG && src == TRMC_SRC_EXT
         && !ext_edge && !man_edge) |=> idle)
        else $error("external source started without edge");
    a_msrc_first: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (idle && mode == TRMC_RUN_TRIG && src == TRMC_SRC_MIX
         && mixfirst_ff && !ext_trig) |=> idle)
        else $error("mixed source first trigger not external");
    a_msrc_later: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (idle && mode == TRMC_RUN_TRIG && src == TRMC_SRC_MIX
         && !mixfirst_ff && !bus_trig_ff) |=> idle)
        else $error("mixed source later trigger not from bus");
    a_lat_busy: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (st_ff == TRMC_ST_LAT) |=> st_ff != TRMC_ST_IDLE)
        else $error("latency phase abandoned");
    a_err_unmap: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (psel_i && penable_i && !mapped) |-> pslverr_o)
        else $error("unmapped access not flagged");
    a_trig_start: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (idle && mode == TRMC_RUN_TRIG && src == TRMC_SRC_BUS
         && bus_trig_ff) |=> st_ff == TRMC_ST_LAT)
        else $error("accepted trigger not started");
endmodule

// ==== testbench/trmc_far_end.sv ====
// Far side model: trigger sources and end-of-cycle pulses of the player
`timescale 1ns/1ps
module trmc_far_end #(
    parameter int CYC_LEN = 5
) (
    input  wire logic sys_clk_i,
    input  wire logic play_i,
    output logic      ext_trig_o,
    output logic      manual_o,
    output logic      cycle_end_o
);
    logic [7:0] cnt_ff = 8'h00;
    initial begin
        ext_trig_o  = 1'b0;
        manual_o    = 1'b0;
        cycle_end_o = 1'b0;
    end
    // Player marks the last sample of every cycle while it plays
    always @(posedge sys_clk_i) begin
        cnt_ff      <= (play_i && cnt_ff < CYC_LEN - 1) ? cnt_ff + 8'h01
                                                       : 8'h00;
        cycle_end_o <= play_i && cnt_ff == CYC_LEN - 1;
    end
    // One trigger per call; rear input or front button
    task automatic pulse(input logic man, input int hold);
        @(posedge sys_clk_i);
        if (man) manual_o <= 1'b1;
        else ext_trig_o <= 1'b1;
        repeat (hold) @(posedge sys_clk_i);
        manual_o   <= 1'b0;
        ext_trig_o <= 1'b0;
    endtask
endmodule

// ==== testbench/test_trigger_run_mode_control.sv ====
// Self-checking bench for the trigger and run-mode sequencer
`timescale 1ns/1ps
`include "trmc_params.svh"
module test_trigger_run_mode_control;
    import trmc_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rst_b_i   = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [11:0] paddr_i   = 12'h000;
    logic [31:0] pwdata_i  = 32'h0;
    logic        gate_i    = 1'b0;
    logic [3:0]  std_i     = 4'h0;
    logic        play_d    = 1'b0;
    logic [31:0] prdata_o, q;
    logic        pready_o, pslverr_o, play_o, output_on_o, err;
    logic        ext_i, man_i, end_i;
    logic [3:0]  fen_o;
    logic [7:0]  fsel_o;
    int          errors = 0, checks_done = 0, rises = 0, ends = 0;
    int          r0, e0, n;

    always #50 sys_clk_i = ~sys_clk_i;

    trmc_core uut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .external_trigger_input_i(ext_i), .manual_trigger_i(man_i),
        .gate_i(gate_i), .cycle_end_i(end_i), .std_shape_i(std_i),
        .play_o(play_o), .output_on_o(output_on_o), .filt_en_o(fen_o),
        .filt_sel_o(fsel_o));
    trmc_far_end far (.sys_clk_i(sys_clk_i), .play_i(play_o),
        .ext_trig_o(ext_i), .manual_o(man_i), .cycle_end_o(end_i));

    // Playback starts and finished cycles, counted for all scenarios
    always @(negedge sys_clk_i) begin
        play_d <= play_o;
        if (play_o === 1'b1 && play_d !== 1'b1) rises <= rises + 1;
        if (end_i === 1'b1) ends <= ends + 1;
    end

    task automatic finish_test;
        if (errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic timeout;
        errors++;
        $display("Error at %0t: wait timed out", $time);
        finish_test();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr_en, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge sys_clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= wr_en;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        q   = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (k >= 20) timeout();
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic lat(output int c);
        c = 0;
        while (play_o !== 1'b1 && c < 100) begin
            @(negedge sys_clk_i);
            c++;
        end
        if (c >= 100) timeout();
    endtask
    // Long tail so a queued or repeated start would still be counted
    task automatic wait_idle;
        int k;
        k = 0;
        while (play_o !== 1'b0 && k < 3000) begin
            @(negedge sys_clk_i);
            k++;
        end
        if (k >= 3000) timeout();
        repeat (30) @(negedge sys_clk_i);
    endtask

    initial begin
        repeat (8) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(negedge sys_clk_i);
        chk(output_on_o, 32'h0);
        rd_chk(`TRMC_ADDR_CTRL, 32'h0);
        repeat (40) @(negedge sys_clk_i);
        chk(play_o, 32'h1);
        chk(rises, 32'h1);
        chk(ends > 5, 32'h1);
        wr(`TRMC_ADDR_CTRL, 32'h49);
        wait_idle();
        chk(output_on_o, 32'h1);
        apb(1'b0, `TRMC_ADDR_STATUS, 32'h0);
        chk(q[4:0], TRMC_ST_IDLE);
        r0 = rises;
        e0 = ends;
        wr(`TRMC_ADDR_CMD, 32'h1);
        lat(n);
        chk(n >= 7 && n <= 9, 32'h1);
        wr(`TRMC_ADDR_CMD, 32'h1);
        wait_idle();
        chk(rises - r0, 32'h1);
        chk(ends - e0, 32'h1);
        far.pulse(1'b0, 2);
        repeat (20) @(negedge sys_clk_i);
        chk(rises - r0, 32'h1);
        wr(`TRMC_ADDR_TRIGDLY, 32'h64);
        wr(`TRMC_ADDR_CMD, 32'h1);
        lat(n);
        chk(n >= 27 && n <= 29, 32'h1);
        wait_idle();
        wr(`TRMC_ADDR_TRIGDLY, 32'h0);
        wr(`TRMC_ADDR_BURST, 32'h3);
        wr(`TRMC_ADDR_CTRL, 32'h4A);
        e0 = ends;
        wr(`TRMC_ADDR_CMD, 32'h1);
        lat(n);
        wait_idle();
        chk(ends - e0, 32'h3);
        wr(`TRMC_ADDR_CTRL, 32'h41);
        r0 = rises;
        far.pulse(1'b0, 2);
        lat(n);
        wait_idle();
        far.pulse(1'b1, 2);
        lat(n);
        wait_idle();
        chk(rises - r0, 32'h2);
        wr(`TRMC_ADDR_CTRL, 32'h61);
        far.pulse(1'b0, 20);
        chk(rises - r0, 32'h2);
        lat(n);
        wait_idle();
        chk(rises - r0, 32'h3);
        wr(`TRMC_ADDR_CTRL, 32'h51);
        wr(`TRMC_ADDR_CMD, 32'h1);
        repeat (20) @(negedge sys_clk_i);
        chk(rises - r0, 32'h3);
        far.pulse(1'b0, 2);
        lat(n);
        wait_idle();
        far.pulse(1'b0, 2);
        repeat (20) @(negedge sys_clk_i);
        chk(rises - r0, 32'h4);
        wr(`TRMC_ADDR_CMD, 32'h1);
        lat(n);
        wait_idle();
        chk(rises - r0, 32'h5);
        wr(`TRMC_ADDR_CTRL, 32'h44);
        far.pulse(1'b0, 2);
        repeat (20) @(negedge sys_clk_i);
        chk(rises - r0, 32'h5);
        wr(`TRMC_ADDR_CMD, 32'h1);
        lat(n);
        wait_idle();
        wr(`TRMC_ADDR_CMD, 32'h1);
        repeat (20) @(negedge sys_clk_i);
        chk(rises - r0, 32'h6);
        far.pulse(1'b0, 2);
        lat(n);
        wait_idle();
        chk(rises - r0, 32'h7);
        wr(`TRMC_ADDR_CTRL, 32'h43);
        e0 = ends;
        @(posedge sys_clk_i);
        gate_i <= 1'b1;
        lat(n);
        @(posedge sys_clk_i);
        gate_i <= 1'b0;
        wait_idle();
        chk(ends - e0, 32'h1);
        chk(output_on_o, 32'h1);
        wr(`TRMC_ADDR_FILTER, 32'h8F1);
        @(negedge sys_clk_i);
        chk(fsel_o, 32'h39);
        chk(fen_o, 32'hA);
        @(posedge sys_clk_i);
        std_i <= 4'h1;
        @(negedge sys_clk_i);
        chk(fen_o, 32'hB);
        rd_chk(`TRMC_ADDR_FILTER, 32'h8F1);
        apb(1'b0, 12'h01C, 32'h0);
        chk(err, 32'h1);
        finish_test();
    end
endmodule
